// *** core/sesr_status_bank.v ***
// Purpose: Measurement, questionable and operation event registers
// Assumes: All condition inputs synchronous to clk
// Notes:   Reads return binary and decimal forms and clear flags
`timescale 1ns/1ps
`include "sesr_regs.vh"

module sesr_status_bank #(
    parameter RD_W      = 24,    // Reading width, signed
    parameter BUF_DEPTH = 1024,  // Trace buffer capacity
    parameter CW        = 11     // Buffer count width
) (
    input  wire                   clk,          // System clock
    input  wire                   reset_n,      // Async reset, low
    // Host read port
    input  wire                   rd_req,       // Read query pulse
    input  wire [1:0]             rd_sel,       // Register select
    output wire                   rd_busy,      // Query in progress
    output reg                    rd_done,      // Answer pulse
    output reg  [15:0]            rd_bin,       // Binary snapshot
    output reg  [19:0]            rd_dec,       // Decimal digits
    // Host enable write port
    input  wire                   en_wr,        // Enable write pulse
    input  wire [1:0]             en_sel,       // Register select
    input  wire [15:0]            en_data,      // New enable mask
    // Measurement engine and limit checker
    input  wire signed [RD_W-1:0] reading,      // Latest reading
    input  wire                   reading_valid,// Reading processed
    input  wire signed [RD_W-1:0] low_limit1,   // First low limit
    input  wire signed [RD_W-1:0] high_limit1,  // First high limit
    input  wire signed [RD_W-1:0] low_limit2,   // Second low limit
    input  wire signed [RD_W-1:0] high_limit2,  // Second high limit
    input  wire                   reading_over_range,  // Overflow
    input  wire                   reading_under_range, // Underflow
    input  wire [CW-1:0]          buf_count,    // Trace buffer fill
    input  wire                   fundamental_too_high, // Freq high
    input  wire                   fundamental_too_low,  // Freq low
    input  wire                   weighting_filter_fault, // Filter
    // Calibration, temperature, command parser
    input  wire                   tc_junction_bad,  // Bad junction
    input  wire                   cal_check_done,   // Power-up check
    input  wire                   cal_constant_bad, // Check failed
    input  wire                   cal_success,      // Cal completed
    input  wire                   param_ignored,    // Param dropped
    // Trigger sequencer
    input  wire                   measuring,    // Measurement active
    input  wire                   trig_action,  // Device action stage
    input  wire                   trig_idle,    // Idle state
    // Status outputs
    output wire [15:0]            meas_flags,   // Measurement flags
    output wire [15:0]            ques_flags,   // Questionable flags
    output wire [15:0]            oper_flags,   // Operation flags
    output reg                    meas_summary, // Enabled meas event
    output reg                    ques_summary, // Enabled ques event
    output reg                    oper_summary, // Enabled oper event
    output reg                    error_indicator, // Error lamp
    output wire                   use_default_cal  // Default cal on
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    // Buffer thresholds, cut to the count width on purpose
    localparam integer  BUF_TWO_I  = 2;
    localparam integer  BUF_HALF_I = BUF_DEPTH / 2;
    localparam integer  BUF_FULL_I = BUF_DEPTH;
    localparam [CW-1:0] BUF_TWO    = BUF_TWO_I[CW-1:0];
    localparam [CW-1:0] BUF_HALF   = BUF_HALF_I[CW-1:0];
    localparam [CW-1:0] BUF_FULL   = BUF_FULL_I[CW-1:0];

    // Select one of three packed slices
    function [15:0] pick;
        input [1:0]  sel;
        input [47:0] vec;
        begin
            case (sel)
                `SESR_SEL_MEAS: pick = vec[15:0];
                `SESR_SEL_QUES: pick = vec[31:16];
                `SESR_SEL_OPER: pick = vec[47:32];
                default:        pick = 16'h0000;
            endcase
        end
    endfunction

    // One-hot decode of a register select
    function [2:0] hit;
        input [1:0] sel;
        begin
            case (sel)
                `SESR_SEL_MEAS: hit = 3'h1;
                `SESR_SEL_QUES: hit = 3'h2;
                `SESR_SEL_OPER: hit = 3'h4;
                default:        hit = 3'h0;
            endcase
        end
    endfunction

    reg  [47:0] flags_r;     // Three event registers, packed
    wire [47:0] flags_nxt;
    reg  [47:0] enable_r;    // Three enable masks, packed
    wire [47:0] set_vec;     // Conditions this cycle
    wire [47:0] clr_vec;     // Bits cleared by a read
    wire [47:0] valid_vec;   // Implemented bit masks
    reg         state_r;
    reg         cal_bad_r;   // Calibration constant invalid
    wire        rd_take;
    wire        conv_done;
    wire [19:0] conv_dec;
    wire [15:0] meas_set;
    wire [15:0] ques_set;
    wire [15:0] oper_set;
    wire [2:0]  rd_hit;
    wire [2:0]  en_hit;

    assign valid_vec = {`SESR_OPER_VALID, `SESR_QUES_VALID,
                        `SESR_MEAS_VALID};

    // Measurement condition bits
    assign meas_set[`SESR_MB_OVER] = reading_over_range;
    assign meas_set[`SESR_MB_LOW1] =
        reading_valid && (reading < low_limit1);
    assign meas_set[`SESR_MB_HIGH1] =
        reading_valid && (reading > high_limit1);
    assign meas_set[`SESR_MB_LOW2] =
        reading_valid && (reading < low_limit2);
    assign meas_set[`SESR_MB_HIGH2] =
        reading_valid && (reading > high_limit2);
    assign meas_set[`SESR_MB_READY] = reading_valid;
    assign meas_set[6] = 1'b0;
    assign meas_set[`SESR_MB_BUF_DATA] =
        (buf_count >= BUF_TWO);
    assign meas_set[`SESR_MB_BUF_HALF] =
        (buf_count >= BUF_HALF);
    assign meas_set[`SESR_MB_BUF_FULL] =
        (buf_count >= BUF_FULL);
    assign meas_set[10] = 1'b0;
    assign meas_set[`SESR_MB_UNDER] = reading_under_range;
    assign meas_set[`SESR_MB_FUND_HIGH] =
        fundamental_too_high;
    assign meas_set[`SESR_MB_FUND_LOW] =
        fundamental_too_low;
    assign meas_set[`SESR_MB_FILT_FAULT] =
        weighting_filter_fault;
    assign meas_set[15] = 1'b0;

    // Questionable condition bits, others zero
    assign ques_set = ({15'h0, tc_junction_bad}
                       << `SESR_QB_TEMP)
                    | ({15'h0, cal_bad_r}
                       << `SESR_QB_CAL)
                    | ({15'h0, param_ignored}
                       << `SESR_QB_WARN);

    // Operation condition bits, others zero
    assign oper_set = ({15'h0, measuring}
                       << `SESR_OB_MEAS)
                    | ({15'h0, trig_action}
                       << `SESR_OB_TRIG)
                    | ({15'h0, trig_idle}
                       << `SESR_OB_IDLE);

    assign set_vec = {oper_set, ques_set, meas_set};

    // Read handshake
    assign rd_take = rd_req && (state_r == ST_IDLE);
    assign rd_busy = (state_r != ST_IDLE);
    assign rd_hit  = rd_take ? hit(rd_sel) : 3'h0;
    assign en_hit  = en_wr ? hit(en_sel) : 3'h0;

    // Next flag values; a new event beats a read clear
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_reg
            assign clr_vec[g*16 +: 16] = {16{rd_hit[g]}};
            assign flags_nxt[g*16 +: 16] =
                ((flags_r[g*16 +: 16] & ~clr_vec[g*16 +: 16])
                 | set_vec[g*16 +: 16])
                & valid_vec[g*16 +: 16];
        end
    endgenerate

    // Event registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= {3{`SESR_FLAGS_RST}};
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Enable masks, implemented bits only
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= {3{`SESR_ENABLE_RST}};
        end else begin
            if (en_hit[0])
                enable_r[15:0]  <= en_data & `SESR_MEAS_VALID;
            if (en_hit[1])
                enable_r[31:16] <= en_data & `SESR_QUES_VALID;
            if (en_hit[2])
                enable_r[47:32] <= en_data & `SESR_OPER_VALID;
        end
    end

    // Summaries gated by enable masks
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meas_summary <= 1'b0;
            ques_summary <= 1'b0;
            oper_summary <= 1'b0;
        end else begin
            meas_summary <= |(flags_nxt[15:0]
                              & enable_r[15:0]);
            ques_summary <= |(flags_nxt[31:16]
                              & enable_r[31:16]);
            oper_summary <= |(flags_nxt[47:32]
                              & enable_r[47:32]);
        end
    end

    // Error lamp follows questionable contents
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            error_indicator <= 1'b0;
        end else begin
            error_indicator <= |flags_nxt[31:16];
        end
    end

    // Calibration condition; a failed check beats success
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_bad_r <= 1'b0;
        end else begin
            if (cal_check_done && cal_constant_bad)
                cal_bad_r <= 1'b1;
            else if (cal_success)
                cal_bad_r <= 1'b0;
        end
    end

    assign use_default_cal = cal_bad_r;

    // Decimal conversion of the read snapshot
    sesr_bin2dec u_conv (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (rd_take),
        .bin_in  (pick(rd_sel, flags_r)),
        .done    (conv_done),
        .dec_out (conv_dec)
    );

    // Read sequencer: snapshot, convert, answer
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            rd_done <= 1'b0;
            rd_bin  <= 16'h0000;
            rd_dec  <= 20'h00000;
        end else begin
            rd_done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (rd_take) begin
                        rd_bin  <= pick(rd_sel, flags_r);
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        rd_dec  <= conv_dec;
                        rd_done <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Register views for the host
    assign meas_flags = flags_r[15:0];
    assign ques_flags = flags_r[31:16];
    assign oper_flags = flags_r[47:32];

endmodule // sesr_status_bank

// *** core/sesr_regs.vh ***
// Purpose: Constants for the status event register bank
// Assumes: Included by the bank and its decimal converter
// Notes:   Bit positions, valid masks, selects and reset values
`ifndef SESR_REGS_VH
`define SESR_REGS_VH

// Register selects on the read and enable ports
`define SESR_SEL_MEAS      2'h0
`define SESR_SEL_QUES      2'h1
`define SESR_SEL_OPER      2'h2

// Measurement event bit positions
`define SESR_MB_OVER       0
`define SESR_MB_LOW1       1
`define SESR_MB_HIGH1      2
`define SESR_MB_LOW2       3
`define SESR_MB_HIGH2      4
`define SESR_MB_READY      5
`define SESR_MB_BUF_DATA   7
`define SESR_MB_BUF_HALF   8
`define SESR_MB_BUF_FULL   9
`define SESR_MB_UNDER      11
`define SESR_MB_FUND_HIGH  12
`define SESR_MB_FUND_LOW   13
`define SESR_MB_FILT_FAULT 14

// Questionable event bit positions
`define SESR_QB_TEMP       4
`define SESR_QB_CAL        8
`define SESR_QB_WARN       14

// Operation event bit positions
`define SESR_OB_MEAS       4
`define SESR_OB_TRIG       5
`define SESR_OB_IDLE       10

// Implemented bits of each register
`define SESR_MEAS_VALID    16'h7bbf
`define SESR_QUES_VALID    16'h4110
`define SESR_OPER_VALID    16'h0430

// Reset values
`define SESR_FLAGS_RST     16'h0000
`define SESR_ENABLE_RST    16'h0000

// Decimal conversion: one shift per source bit
`define SESR_CONV_CYCLES   5'h10
`define SESR_DEC_W         20

`endif

// *** core/sesr_bin2dec.v ***
// Purpose: Sequential 16-bit binary to 5-digit BCD converter
// Assumes: start is a one-cycle pulse taken only while idle
// Notes:   Result appears 16 edges after start, done for 1 cycle
`timescale 1ns/1ps
`include "sesr_regs.vh"

module sesr_bin2dec (
    input  wire        clk,      // System clock
    input  wire        reset_n,  // Async reset, active low
    input  wire        start,    // Load value and begin
    input  wire [15:0] bin_in,   // Binary value to convert
    output reg         done,     // One-cycle result pulse
    output reg  [19:0] dec_out   // Five BCD digits, LSD low
);

    reg  [35:0] sh_r;   // BCD digits above binary remainder
    reg  [4:0]  cnt_r;  // Shifts done
    reg         act_r;  // Conversion running
    wire [19:0] adj;    // Digits after add-3 correction
    wire [35:0] shifted;

    // Add three to every digit of five or more
    genvar d;
    generate
        for (d = 0; d < 5; d = d + 1) begin : g_dig
            assign adj[d*4 +: 4] = (sh_r[16+d*4 +: 4] >= 4'h5) ?
                                   sh_r[16+d*4 +: 4] + 4'h3 :
                                   sh_r[16+d*4 +: 4];
        end
    endgenerate

    assign shifted = {adj[18:0], sh_r[15:0], 1'b0};

    // Shift loop and result capture
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sh_r    <= 36'h0;
            cnt_r   <= 5'h0;
            act_r   <= 1'b0;
            done    <= 1'b0;
            dec_out <= 20'h0;
        end else begin
            done <= 1'b0;
            if (start && !act_r) begin
                sh_r  <= {20'h0, bin_in};
                cnt_r <= 5'h0;
                act_r <= 1'b1;
            end else if (act_r) begin
                sh_r  <= shifted;
                cnt_r <= cnt_r + 5'h1;
                if (cnt_r == `SESR_CONV_CYCLES - 5'h1) begin
                    act_r   <= 1'b0;
                    done    <= 1'b1;
                    dec_out <= shifted[35:16];
                end
            end
        end
    end

endmodule // sesr_bin2dec

// *** tb/sesr_status_bank_sva.sv ***
// Purpose: Port checks for the status event register bank
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every bank instance
`timescale 1ns/1ps
`include "sesr_regs.vh"

module sesr_chk #(
    parameter CW = 11                        // Buffer count width
) (
    input wire          clk,                 // System clock
    input wire          reset_n,             // Async reset, low
    input wire          rd_req,              // Read query
    input wire [1:0]    rd_sel,              // Register select
    input wire          rd_busy,             // Query in progress
    input wire          rd_done,             // Answer pulse
    input wire [15:0]   rd_bin,              // Binary answer
    input wire [19:0]   rd_dec,              // Decimal answer
    input wire          reading_over_range,  // Overflow
    input wire [CW-1:0] buf_count,           // Buffer fill
    input wire          measuring,           // Measuring
    input wire          trig_action,         // Device action
    input wire          trig_idle,           // Idle
    input wire [15:0]   meas_flags,          // Measurement flags
    input wire [15:0]   ques_flags,          // Questionable flags
    input wire [15:0]   oper_flags,          // Operation flags
    input wire          ques_summary,        // Ques summary
    input wire          error_indicator,     // Error lamp
    input wire          use_default_cal      // Default cal
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Query taken on this edge
    wire take = rd_req && !rd_busy;

    // Value of five decimal digits
    function automatic integer dval(input [19:0] d);
        dval = d[3:0] + 10 * d[7:4] + 100 * d[11:8]
             + 1000 * d[15:12] + 10000 * d[19:16];
    endfunction

    // Read timing, decimal answer, snapshot and clear
    property p_answer; take |-> ##17 rd_busy ##1 (rd_done && !rd_busy);
    endproperty
    a_answer: assert property (p_answer) else $error("answer late");
    property p_dec; rd_done |-> dval(rd_dec) == rd_bin; endproperty
    a_dec: assert property (p_dec) else $error("decimal wrong");
    property p_snap;
        take && rd_sel == `SESR_SEL_MEAS |=> rd_bin == $past(meas_flags);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot wrong");
    property p_clear;
        take && rd_sel == `SESR_SEL_OPER && !measuring && !trig_action
            && !trig_idle |=> oper_flags == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("not cleared");

    // Latching, condition bits, unused bits and error lamp
    property p_latch; oper_flags[4] && !take |=> oper_flags[4]; endproperty
    a_latch: assert property (p_latch) else $error("bit lost");
    property p_meas; measuring |=> oper_flags[`SESR_OB_MEAS]; endproperty
    a_meas: assert property (p_meas) else $error("meas bit");
    property p_over; reading_over_range |=> meas_flags[0]; endproperty
    a_over: assert property (p_over) else $error("over bit");
    property p_buf; buf_count >= 2 |=> meas_flags[7]; endproperty
    a_buf: assert property (p_buf) else $error("buffer bit");
    property p_unused;
        ((meas_flags & ~`SESR_MEAS_VALID) | (ques_flags & ~`SESR_QUES_VALID)
            | (oper_flags & ~`SESR_OPER_VALID)) == 16'h0000;
    endproperty
    a_unused: assert property (p_unused) else $error("unused set");
    property p_err; error_indicator == (ques_flags != 16'h0000); endproperty
    a_err: assert property (p_err) else $error("error lamp");

    // Main scenarios reached
    c_read: cover property (take ##18 rd_done);
    c_sum: cover property (ques_summary);
    c_cal: cover property (use_default_cal);
endmodule // sesr_chk

bind sesr_status_bank sesr_chk #(.CW(CW)) u_chk (.clk, .reset_n, .rd_req,
    .rd_sel, .rd_busy, .rd_done, .rd_bin, .rd_dec, .reading_over_range,
    .buf_count, .measuring, .trig_action, .trig_idle, .meas_flags,
    .ques_flags, .oper_flags, .ques_summary, .error_indicator,
    .use_default_cal);

// *** tb/sesr_host.sv ***
// Purpose: Host side issuing status queries and enable writes
// Assumes: One query outstanding at a time
// Notes:   Query reports a timeout through its ok output
`timescale 1ns/1ps

module sesr_host (
    input  wire        clk,     // System clock
    input  wire        rd_busy, // Query in progress
    input  wire        rd_done, // Answer pulse
    input  wire [15:0] rd_bin,  // Binary answer
    input  wire [19:0] rd_dec,  // Decimal answer
    output reg         rd_req,  // Read query
    output reg  [1:0]  rd_sel,  // Register select
    output reg         en_wr,   // Enable write
    output reg  [1:0]  en_sel,  // Enable select
    output reg  [15:0] en_data  // Enable mask
);
    // Idle bus from time zero
    initial begin
        rd_req = 1'b0;
        rd_sel = 2'h0;
        en_wr = 1'b0;
        en_sel = 2'h0;
        en_data = 16'h0000;
    end

    // Query: request taken at the next edge, answer awaited
    task query(input [1:0] s, output [15:0] b, output [19:0] d,
               output ok);
        integer k;
        begin
            ok = 1'b0;
            @(posedge clk) rd_req <= 1'b1;
            rd_sel <= s;
            @(posedge clk) rd_req <= 1'b0;
            for (k = 0; k < 30 && !ok; k = k + 1) begin
                @(posedge clk);
                #1;
                if (rd_done === 1'b1) begin
                    ok = 1'b1;
                    b = rd_bin;
                    d = rd_dec;
                end
            end
        end
    endtask

    // Enable mask write, one cycle
    task wr(input [1:0] s, input [15:0] v);
        begin
            @(posedge clk) en_wr <= 1'b1;
            en_sel <= s;
            en_data <= v;
            @(posedge clk) en_wr <= 1'b0;
        end
    endtask
endmodule // sesr_host

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the status event register bank
// Assumes: Host model makes all register accesses
// Notes:   Trace buffer depth 16 keeps buffer checks short
`timescale 1ns/1ps
`include "sesr_regs.vh"

module tb;
    reg               clk, reset_n, reading_valid;
    reg               cal_check_done, cal_constant_bad, cal_success;
    reg        [9:0]  lv;
    reg signed [23:0] reading;
    reg        [4:0]  buf_count;
    reg        [17:0] t;
    wire              rd_req, rd_busy, rd_done, en_wr, meas_summary;
    wire              ques_summary, oper_summary, error_indicator;
    wire              use_default_cal;
    wire       [1:0]  rd_sel, en_sel;
    wire       [15:0] rd_bin, en_data, meas_flags, ques_flags, oper_flags;
    wire       [19:0] rd_dec;
    integer           n_errors, total_checks, i;

    // Bank under test, fixed limits 0/10 and -10/-8
    sesr_status_bank #(.RD_W(24), .BUF_DEPTH(16), .CW(5)) dut (
        .clk, .reset_n, .rd_req, .rd_sel, .rd_busy, .rd_done, .rd_bin,
        .rd_dec, .en_wr, .en_sel, .en_data, .reading, .reading_valid,
        .low_limit1(24'sd0), .high_limit1(24'sd10),
        .low_limit2(-24'sd10), .high_limit2(-24'sd8),
        .reading_over_range(lv[0]), .reading_under_range(lv[1]),
        .fundamental_too_high(lv[2]), .fundamental_too_low(lv[3]),
        .weighting_filter_fault(lv[4]), .tc_junction_bad(lv[5]),
        .param_ignored(lv[6]), .measuring(lv[7]), .trig_action(lv[8]),
        .trig_idle(lv[9]), .buf_count, .cal_check_done, .cal_constant_bad,
        .cal_success, .meas_flags, .ques_flags, .oper_flags, .meas_summary,
        .ques_summary, .oper_summary, .error_indicator, .use_default_cal);

    sesr_host host (.clk, .rd_busy, .rd_done, .rd_bin, .rd_dec, .rd_req,
                    .rd_sel, .en_wr, .en_sel, .en_data);

    // Clock
    always #5 clk = ~clk;

    // Register and bit set by each level condition
    function [17:0] tab(input integer k);
        case (k)
            0: tab = {`SESR_SEL_MEAS, 16'h0001};
            1: tab = {`SESR_SEL_MEAS, 16'h0800};
            2: tab = {`SESR_SEL_MEAS, 16'h1000};
            3: tab = {`SESR_SEL_MEAS, 16'h2000};
            4: tab = {`SESR_SEL_MEAS, 16'h4000};
            5: tab = {`SESR_SEL_QUES, 16'h0010};
            6: tab = {`SESR_SEL_QUES, 16'h4000};
            7: tab = {`SESR_SEL_OPER, 16'h0010};
            8: tab = {`SESR_SEL_OPER, 16'h0020};
            default: tab = {`SESR_SEL_OPER, 16'h0400};
        endcase
    endfunction

    // Five decimal digits of a value
    function [19:0] bcd(input [15:0] v);
        integer k;
        begin
            for (k = 0; k < 5; k = k + 1) begin
                bcd[4*k +: 4] = v % 10;
                v = v / 10;
            end
        end
    endfunction

    // Compare helpers
    task chkv(input [19:0] g, input [19:0] e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t value %h expected %h", $time, g, e);
            end
        end
    endtask
    task chk1(input g, input e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t flag %b expected %b", $time, g, e);
            end
        end
    endtask

    // Closing report
    task give_verdict;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // Query a register, check binary and decimal answers
    task rd(input [1:0] s, input [15:0] e);
        reg [15:0] b;
        reg [19:0] d;
        reg        ok;
        begin
            host.query(s, b, d, ok);
            if (!ok) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %0t no answer", $time);
                give_verdict;
            end
            chkv({4'h0, b}, {4'h0, e});
            chkv(d, bcd(e));
        end
    endtask

    // Stimulus helpers
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task pl(input [9:0] m);
        begin
            @(posedge clk) lv <= m;
            @(posedge clk) lv <= 10'h000;
        end
    endtask
    task bufchk(input [4:0] c, input [15:0] e);
        begin
            @(posedge clk) buf_count <= c;
            @(posedge clk) buf_count <= 5'h00;
            rd(`SESR_SEL_MEAS, e);
        end
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        lv = 10'h000;
        reading = 24'sd0;
        reading_valid = 1'b0;
        buf_count = 5'h00;
        cal_check_done = 1'b0;
        cal_constant_bad = 1'b0;
        cal_success = 1'b0;
        n_errors = 0;
        total_checks = 0;
        tick(6);
        reset_n <= 1'b1;
        tick(2);
        #1;
        chkv({4'h0, meas_flags | ques_flags | oper_flags}, 20'h0);
        for (i = 0; i < 10; i = i + 1) begin
            t = tab(i);
            pl(10'h001 << i);
            tick(3);
            rd(t[17:16], t[15:0]);
            rd(t[17:16], 16'h0000);
        end
        bufchk(5'd1, 16'h0000);
        bufchk(5'd2, 16'h0080);
        bufchk(5'd7, 16'h0080);
        bufchk(5'd8, 16'h0180);
        bufchk(5'd16, 16'h0380);
        // Every measurement event at once, two limit readings
        @(posedge clk) lv <= 10'h01f;
        buf_count <= 5'd16;
        reading <= 24'sd20;
        reading_valid <= 1'b1;
        @(posedge clk) reading <= -24'sd20;
        @(posedge clk) reading_valid <= 1'b0;
        lv <= 10'h000;
        buf_count <= 5'h00;
        rd(`SESR_SEL_MEAS, 16'h7bbf);
        pl(10'h001);
        rd(2'h3, 16'h0000);
        rd(`SESR_SEL_MEAS, 16'h0001);
        // Bad calibration constant held until calibrated
        @(posedge clk) cal_check_done <= 1'b1;
        cal_constant_bad <= 1'b1;
        @(posedge clk) cal_check_done <= 1'b0;
        cal_constant_bad <= 1'b0;
        tick(1);
        #1;
        chk1(use_default_cal, 1'b1);
        chk1(error_indicator, 1'b1);
        rd(`SESR_SEL_QUES, 16'h0100);
        rd(`SESR_SEL_QUES, 16'h0100);
        @(posedge clk) cal_success <= 1'b1;
        @(posedge clk) cal_success <= 1'b0;
        rd(`SESR_SEL_QUES, 16'h0100);
        rd(`SESR_SEL_QUES, 16'h0000);
        chk1(use_default_cal, 1'b0);
        chk1(error_indicator, 1'b0);
        // Summaries pass only enabled events
        host.wr(`SESR_SEL_QUES, 16'h4000);
        host.wr(`SESR_SEL_OPER, 16'h0400);
        pl(10'h020);
        tick(1);
        #1;
        chk1(ques_summary, 1'b0);
        pl(10'h240);
        tick(1);
        #1;
        chk1(ques_summary, 1'b1);
        chk1(oper_summary, 1'b1);
        chk1(meas_summary, 1'b0);
        rd(`SESR_SEL_QUES, 16'h4010);
        chk1(ques_summary, 1'b0);
        give_verdict;
    end
endmodule // tb
